// ==== mtt_pkg.sv ====
/*
 * Constants for the touch tag look-up register bank: byte offsets,
 * field positions, widths and reset values.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package mtt_pkg;

	localparam int DATA_W   = 32;
	localparam int TAG_W    = 8;
	localparam int COORD_W  = 32;
	localparam int NUM_TAGS = 5;
	localparam int NUM_XY   = 3;
	localparam int ADDR_W   = 12;

	// Coordinate fields inside a look-up coordinate word
	localparam int COORD_X_MSB = 31;
	localparam int COORD_X_LSB = 16;
	localparam int COORD_Y_MSB = 15;
	localparam int COORD_Y_LSB = 0;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] TOUCH1_LOOKUP_COORD_OFF = 12'h128;
	localparam logic [ADDR_W-1:0] TOUCH1_OBJECT_TAG_OFF   = 12'h12C;
	localparam logic [ADDR_W-1:0] TOUCH2_LOOKUP_COORD_OFF = 12'h130;
	localparam logic [ADDR_W-1:0] TOUCH2_OBJECT_TAG_OFF   = 12'h134;
	localparam logic [ADDR_W-1:0] TOUCH3_LOOKUP_COORD_OFF = 12'h138;
	localparam logic [ADDR_W-1:0] TOUCH3_OBJECT_TAG_OFF   = 12'h13C;
	localparam logic [ADDR_W-1:0] TOUCH4_OBJECT_TAG_OFF   = 12'h144;
	localparam logic [ADDR_W-1:0] TOUCH5_OBJECT_TAG_OFF   = 12'h14C;

	localparam logic [NUM_TAGS-1:0][ADDR_W-1:0] TAG_OFF = {
		TOUCH5_OBJECT_TAG_OFF, TOUCH4_OBJECT_TAG_OFF,
		TOUCH3_OBJECT_TAG_OFF, TOUCH2_OBJECT_TAG_OFF,
		TOUCH1_OBJECT_TAG_OFF};
	localparam logic [NUM_XY-1:0][ADDR_W-1:0] XY_OFF = {
		TOUCH3_LOOKUP_COORD_OFF, TOUCH2_LOOKUP_COORD_OFF,
		TOUCH1_LOOKUP_COORD_OFF};

	// Reset values; a zero tag means nothing is touched
	localparam logic [TAG_W-1:0]   TAG_RESET   = 8'h00;
	localparam logic [COORD_W-1:0] COORD_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0]  RDATA_IDLE  = 32'h0000_0000;

endpackage : mtt_pkg

// ==== mtt_snap_reg.sv ====
/*
 * One frame snapshot register: loads a value or zero on a frame-end
 * pulse and holds it otherwise.
 * Assumes load and its data come from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module mtt_snap_reg
	import mtt_pkg::*;
#(
	parameter int                W     = TAG_W,
	parameter logic [W-1:0]      RST_V = '0
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Snapshot control
	input  wire logic         load,
	input  wire logic         zero,
	input  wire logic [W-1:0] d,
	// Held value
	output logic      [W-1:0] q
);

	if (W < 1)
	begin : g_bad_w
		$error("W must be at least 1");
	end

	logic [W-1:0] valQ;
	logic [W-1:0] valD;

	always_comb
	begin
		valD = valQ;
		if (load)
			valD = zero ? '0 : d;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			valQ <= RST_V;
		else
			valQ <= valD;
	end

	assign q = valQ;

endmodule : mtt_snap_reg
`default_nettype wire

// ==== mtt_tag_regs.sv ====
/*
 * Touch tag look-up register bank: five object tag registers and three
 * look-up coordinate registers, refreshed once per frame, read over APB.
 * Assumes the touch engine and the scan-out logic run on clk and give
 * a one-cycle frame-end pulse.
 */
`timescale 1ns/1ns
`default_nettype none

// Operation
// (RQ1) Tags of touch points three to five sit in bits 7..0, upper bits zero.
// (RQ2) Every tag register is refreshed once per frame at frame end only.
// (RQ3) Tags reset to zero, zero meaning no touch, valid tags 1 to 255.
// (RQ4) Tags two to five carry values only in extended mode.
// (RQ5) A coordinate word holds X in bits 31..16 and Y in bits 15..0.
// (RQ6) Coordinate registers one to three belong to tags one to three.
// (RQ7) Coordinate registers reset to zero and are read-only.
// (RQ8) The first tag is an eight-bit read-only register in both modes.
// (RQ9) The second tag is an eight-bit read-only register, extended mode.
// (RQ10) Host writes to tag or coordinate registers change nothing.
module mtt_tag_regs
	import mtt_pkg::*;
#(
	parameter int PADDR_W = ADDR_W
)
(
	// Clock and reset
	input  wire logic                             clk,
	input  wire logic                             rst_n,
	// APB slave
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [PADDR_W-1:0]               paddr,
	input  wire logic [DATA_W-1:0]                pwdata,
	output logic      [DATA_W-1:0]                prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	// Touch engine results
	input  wire logic                             extendedMode,
	input  wire logic                             frameDone,
	input  wire logic [NUM_TAGS-1:0][TAG_W-1:0]   tagIn,
	input  wire logic [NUM_XY-1:0][COORD_W-1:0]   coordIn
);

	if (PADDR_W < ADDR_W || PADDR_W > DATA_W)
	begin : g_bad_addr_w
		$error("PADDR_W must lie between 12 and 32");
	end

	logic [NUM_TAGS-1:0][TAG_W-1:0]  tagQ;
	logic [NUM_XY-1:0][COORD_W-1:0]  coordQ;
	logic [DATA_W-1:0]               rdataQ;
	logic [DATA_W-1:0]               rdataD;
	logic                            errQ;
	logic                            errD;
	logic                            hit;
	logic [ADDR_W-1:0]               addr;
	logic                            setup;

	assign addr  = paddr[ADDR_W-1:0];
	assign setup = psel && !penable;

	// Frame-end snapshots; points two onward are zero outside extended mode
	genvar gi;
	generate
		for (gi = 0; gi < NUM_TAGS; gi++)
		begin : g_tag
			mtt_snap_reg #(
				.W     (TAG_W),
				.RST_V (TAG_RESET)   // see RQ3
			) u_tag (
				.clk   (clk),
				.rst_n (rst_n),
				.load  (frameDone),                  // see RQ2
				.zero  ((gi != 0) && !extendedMode), // see RQ4
				.d     (tagIn[gi]),                  // see RQ8 RQ9
				.q     (tagQ[gi])
			);
		end
		for (gi = 0; gi < NUM_XY; gi++)
		begin : g_xy
			mtt_snap_reg #(
				.W     (COORD_W),
				.RST_V (COORD_RESET) // see RQ7
			) u_xy (
				.clk   (clk),
				.rst_n (rst_n),
				.load  (frameDone),                  // see RQ6
				.zero  ((gi != 0) && !extendedMode), // see RQ4
				.d     (coordIn[gi]),
				.q     (coordQ[gi])
			);
		end
	endgenerate

	// Read mux, sampled in the setup phase; writes are accepted and dropped
	always_comb
	begin
		rdataD = rdataQ;
		errD   = errQ;
		hit    = 1'b0;
		if (setup)
		begin
			rdataD = RDATA_IDLE;
			for (int i = 0; i < NUM_TAGS; i++)
			begin
				if (addr == TAG_OFF[i])
				begin
					hit    = 1'b1;
					rdataD = {{(DATA_W-TAG_W){1'b0}}, tagQ[i]}; // see RQ1
				end
			end
			for (int i = 0; i < NUM_XY; i++)
			begin
				if (addr == XY_OFF[i])
				begin
					hit    = 1'b1;
					rdataD = coordQ[i]; // see RQ5
				end
			end
			if (pwrite)
				rdataD = RDATA_IDLE; // see RQ10
			if (PADDR_W > ADDR_W)
				hit = hit && (paddr >> ADDR_W) == '0;
			errD = !hit;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rdataQ <= RDATA_IDLE;
			errQ   <= 1'b0;
		end
		else
		begin
			rdataQ <= rdataD;
			errQ   <= errD;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = rdataQ;
	assign pslverr = errQ && psel && penable;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence sReadSetup(logic [ADDR_W-1:0] a);
		psel && !penable && !pwrite && addr == a;
	endsequence
	sequence sAccess;
		psel && penable;
	endsequence
	sequence sWriteAccess;
		psel && penable && pwrite;
	endsequence

	chk_tag_reset: assert property ( // see RQ3
		$rose(rst_n) |-> tagQ == '0 && coordQ == '0)
		else $error("tag or coordinate not zero after reset");
	chk_tag_hold: assert property ( // see RQ2
		!frameDone |=> $stable(tagQ) && $stable(coordQ))
		else $error("register changed outside frame end");
	chk_first_tag: assert property ( // see RQ8
		frameDone |=> tagQ[0] == $past(tagIn[0]))
		else $error("first tag not loaded at frame end");
	chk_ext_tags: assert property ( // see RQ1
		frameDone && extendedMode |=> tagQ[2] == $past(tagIn[2])
			&& tagQ[3] == $past(tagIn[3]) && tagQ[4] == $past(tagIn[4]))
		else $error("extended tags not loaded");
	chk_compat_zero: assert property ( // see RQ4
		frameDone && !extendedMode |=> tagQ[1] == '0 && tagQ[4] == '0
			&& coordQ[2] == '0)
		else $error("compatibility mode left stale values");
	chk_coord_load: assert property ( // see RQ6
		frameDone |=> coordQ[0] == $past(coordIn[0]))
		else $error("first coordinate not loaded");
	chk_write_drop: assert property ( // see RQ10
		sWriteAccess ##0 !frameDone |=> $stable(tagQ) && $stable(coordQ))
		else $error("host write altered a register");
	chk_coord_read: assert property ( // see RQ5
		sReadSetup(TOUCH1_LOOKUP_COORD_OFF) ##1 sAccess
			|-> prdata[COORD_X_MSB:COORD_X_LSB]
				== $past(coordQ[0][COORD_X_MSB:COORD_X_LSB])
			&& prdata[COORD_Y_MSB:COORD_Y_LSB]
				== $past(coordQ[0][COORD_Y_MSB:COORD_Y_LSB]))
		else $error("coordinate read returned wrong fields");
	chk_tag_upper: assert property ( // see RQ9
		sReadSetup(TOUCH2_OBJECT_TAG_OFF) ##1 sAccess
			|-> prdata == {24'h000000, $past(tagQ[1])} && !pslverr)
		else $error("second tag read wrong or upper bits set");
	chk_coord_ro: assert property ( // see RQ7
		sWriteAccess ##0 addr == TOUCH3_LOOKUP_COORD_OFF ##0 !frameDone
			|=> coordQ[2] == $past(coordQ[2]))
		else $error("coordinate register was writable");

	// Register reads, mode loading and masking, and reset of the coordinates and read port
	chk_first_read: assert property ( // see RQ8
		sReadSetup(TOUCH1_OBJECT_TAG_OFF) ##1 sAccess
			|-> prdata == {24'h000000, $past(tagQ[0])} && !pslverr)
		else $error("first tag read wrong or upper bits set");
	chk_fifth_read: assert property ( // see RQ1
		sReadSetup(TOUCH5_OBJECT_TAG_OFF) ##1 sAccess
			|-> prdata == {24'h000000, $past(tagQ[4])} && !pslverr)
		else $error("fifth tag read wrong or upper bits set");
	chk_third_coord: assert property ( // see RQ6
		sReadSetup(TOUCH3_LOOKUP_COORD_OFF) ##1 sAccess
			|-> prdata == $past(coordQ[2]) && !pslverr)
		else $error("third coordinate read wrong");
	chk_ext_second: assert property ( // see RQ9
		frameDone && extendedMode |=> tagQ[1] == $past(tagIn[1])
			&& coordQ[1] == $past(coordIn[1])
			&& coordQ[2] == $past(coordIn[2]))
		else $error("second point values not loaded");
	chk_compat_rest: assert property ( // see RQ4
		frameDone && !extendedMode |=> tagQ[2] == '0 && tagQ[3] == '0
			&& coordQ[1] == '0)
		else $error("compatibility mode kept middle values");
	chk_coord_reset: assert property ( // see RQ7
		$rose(rst_n) |-> coordQ == '0 && prdata == RDATA_IDLE && !pslverr)
		else $error("coordinate or read port not idle after reset");

endmodule : mtt_tag_regs
`default_nettype wire

// ==== mtt_tag_regs_tb_top.sv ====
/* Self-checking testbench for the touch tag register bank.
   Assumes mtt_pkg and mtt_tag_regs are compiled before it. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin errTotal++; \
	$display("[ERR] %s at %h exp %h got %h", n, paddr, e, g); end end

module mtt_tag_regs_tb_top
	import mtt_pkg::*;
;
	logic                               clk = 1'h0;
	logic                               rstN, psel, penable, pwrite;
	logic                               pready, pslverr, extMode, frameDone;
	logic                               rdErr;
	logic [ADDR_W-1:0]                  paddr;
	logic [DATA_W-1:0]                  pwdata, prdata, rd;
	logic [NUM_TAGS-1:0][TAG_W-1:0]     tagIn, expTag;
	logic [NUM_XY-1:0][COORD_W-1:0]     coordIn, expCoord;
	int                                 errTotal = 0;
	int                                 testsRun = 0;

	always #4 clk = ~clk;

	mtt_tag_regs uut (.clk(clk), .rst_n(rstN), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .extendedMode(extMode),
		.frameDone(frameDone), .tagIn(tagIn), .coordIn(coordIn));

	task automatic apbXfer(input logic [ADDR_W-1:0] a, input logic w);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'hFFFF_FFFF;
		@(posedge clk);
		penable <= 1'h1;
		do
		begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		rdErr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask : apbXfer

	task automatic rdChk(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] e, input logic ee);
		apbXfer(a, 1'h0);
		`CHK("prdata", e, rd)
		`CHK("pslverr", ee, rdErr)
	endtask : rdChk

	// One frame-end pulse carrying new engine results
	task automatic frame(input logic m, input logic [7:0] b);
		extMode <= m;
		frameDone <= 1'h1;
		for (int i = 0; i < NUM_TAGS; i++)
			tagIn[i] <= b + 8'(i * 8'h33);
		for (int i = 0; i < NUM_XY; i++)
			coordIn[i] <= {8'h0, b, 8'(i), 8'hC0 + 8'(i)};
		@(posedge clk);
		frameDone <= 1'h0;
		@(posedge clk);
	endtask : frame

	// Every register against the last frame, masked by the mode
	task automatic chkAll(input logic m, input logic z);
		for (int i = 0; i < NUM_TAGS; i++)
			rdChk(TAG_OFF[i], (z || (i > 0 && !m)) ? '0 :
				{24'h0, tagIn[i]}, 1'h0);
		for (int i = 0; i < NUM_XY; i++)
			rdChk(XY_OFF[i], (z || (i > 0 && !m)) ? '0 :
				coordIn[i], 1'h0);
	endtask : chkAll

	// Engine inputs move without a frame end; writes change nothing
	task automatic holdAndWrite();
		tagIn <= ~tagIn;
		coordIn <= ~coordIn;
		repeat (3) @(posedge clk);
		tagIn <= ~tagIn;
		coordIn <= ~coordIn;
		for (int i = 0; i < NUM_TAGS; i++)
		begin
			apbXfer(TAG_OFF[i], 1'h1);
			`CHK("wr pslverr", 1'h0, rdErr)
		end
		for (int i = 0; i < NUM_XY; i++)
		begin
			apbXfer(XY_OFF[i], 1'h1);
			`CHK("wr pslverr", 1'h0, rdErr)
		end
		apbXfer(12'h140, 1'h1);
		`CHK("wr pslverr", 1'h1, rdErr)
		chkAll(1'h1, 1'h0);
		rdChk(12'h140, '0, 1'h1);
	endtask : holdAndWrite

	task results;
		if (errTotal == 0 && testsRun > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	initial
	begin
		#20000;
		errTotal++;
		results();
	end

	initial
	begin
		{rstN, psel, penable, pwrite, extMode, frameDone} = '0;
		paddr = '0;
		pwdata = '0;
		tagIn = '0;
		coordIn = '0;
		repeat (20) @(posedge clk);
		rstN <= 1'h1;
		@(posedge clk);
		chkAll(1'h1, 1'h1);
		frame(1'h1, 8'hCC);
		chkAll(1'h1, 1'h0);
		holdAndWrite();
		frame(1'h0, 8'h01);
		chkAll(1'h0, 1'h0);
		results();
	end
endmodule : mtt_tag_regs_tb_top

`default_nettype wire
